// File: hdl/cps_pkg.sv
// Package: constants and carrier types for the channel plan selector
package cps_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SIG_DWELL_MS  = 500;
  localparam int unsigned HEART_PER_MS  = 1000;
  localparam int unsigned SIG_DWELL_CYC =
    (SIG_DWELL_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int unsigned HEART_HALF_CYC =
    (HEART_PER_MS * 1000) / CLK_PERIOD_NS * 1000 / 2;
  // Selector and channel field widths
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned CHAN_N  = 7;
  localparam int unsigned CHNUM_W = 3;
  // Signalling channel numbers used by plans
  localparam logic [2:0] SIG_CH2 = 3'h2;
  localparam logic [2:0] SIG_CH3 = 3'h3;
  localparam logic [2:0] SIG_CH4 = 3'h4;
  localparam logic [2:0] SIG_CH5 = 3'h5;
  localparam logic [2:0] SIG_CH7 = 3'h7;
  localparam logic [2:0] SIG_NONE = 3'h0;
  // Operating channel masks, bit n-1 is channel n
  localparam logic [6:0] OP_1_4   = 7'h09;
  localparam logic [6:0] OP_5_7   = 7'h50;
  localparam logic [6:0] OP_3_6   = 7'h24;
  localparam logic [6:0] OP_1_5   = 7'h11;
  localparam logic [6:0] OP_2_6   = 7'h22;
  localparam logic [6:0] OP_4_6   = 7'h28;
  localparam logic [6:0] OP_1_3_7 = 7'h45;
  localparam logic [6:0] OP_NONE  = 7'h00;
  // Reset values
  localparam logic [3:0] SEL_RST  = 4'h0;

  // Decoded channel plan
  typedef struct packed {
    logic       auto_search; // Custom group search mode
    logic [2:0] sig_chan;    // Signalling channel, 0 when searching
    logic [6:0] op_mask;     // Operating channels
  } cps_plan_s;

  // Call setup phases
  typedef enum logic [1:0] {
    CPS_IDLE,
    CPS_SIGNAL,
    CPS_OPERATE
  } cps_phase_e;
endpackage

// File: hdl/cps_top.sv
// Channel plan selector: switch capture, plan decode, dwell, heartbeat
`timescale 1ns/1ps

// Behaviour
// - Hex selector zero..fifteen chooses channel plan
// - Selector captured at reset release only
// - Positions 1-6 signal ch7, operate ch=pos
// - Positions 7-9 signal ch2, paired operating
// - Positions A-D use their own plans
// - Positions E,F reserved, no fixed plan
// - Zero selects custom group channel search
// - Dwell half second on signalling channel
// - Heartbeat flashes once per second
// - Both link ends use same selector
module cps_top #(
  parameter int unsigned DWELL_CYC = cps_pkg::SIG_DWELL_CYC,
  parameter int unsigned HEART_CYC = cps_pkg::HEART_HALF_CYC
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Rotary selector
  input  wire logic [3:0]            sel_switch,
  // Call setup
  input  wire logic                  call_start,
  input  wire logic                  call_end,
  // Plan and channel outputs
  output cps_pkg::cps_plan_s         plan,
  output logic [3:0]                 sel_value,
  output logic                       on_signal,
  output logic                       on_operate,
  // Heartbeat LED
  output logic                       heartbeat
);

  // Synchroniser stages; the first is read by the second only
  logic [3:0] sync1_ff, nxt_sync1;
  logic [3:0] sync2_ff, nxt_sync2;
  // Captured selector and its decoded plan
  logic [3:0] sel_ff, nxt_sel;
  cps_pkg::cps_plan_s plan_ff, nxt_plan;
  // Delayed reset marks the release edge
  logic       rst_d_ff, nxt_rst_d;
  // Call phase and dwell counter
  cps_pkg::cps_phase_e phase_ff, nxt_phase;
  logic [31:0] dwell_ff, nxt_dwell;
  // Heartbeat divider
  logic [31:0] beat_ff, nxt_beat;
  logic        led_ff, nxt_led;

  // Plan lookup for one selector value
  function automatic cps_pkg::cps_plan_s decode(input logic [3:0] s);
    cps_pkg::cps_plan_s p;
    p = '{auto_search: 1'b0, sig_chan: cps_pkg::SIG_NONE,
          op_mask: cps_pkg::OP_NONE};
    case (s)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
      begin
        p.sig_chan = cps_pkg::SIG_CH7;
        p.op_mask  = 7'(7'h01 << (s - 4'h1));
      end
      4'h7:
      begin
        p.sig_chan = cps_pkg::SIG_CH2;
        p.op_mask  = cps_pkg::OP_1_4;
      end
      4'h8:
      begin
        p.sig_chan = cps_pkg::SIG_CH2;
        p.op_mask  = cps_pkg::OP_5_7;
      end
      4'h9:
      begin
        p.sig_chan = cps_pkg::SIG_CH2;
        p.op_mask  = cps_pkg::OP_3_6;
      end
      4'hA:
      begin
        p.sig_chan = cps_pkg::SIG_CH3;
        p.op_mask  = cps_pkg::OP_1_5;
      end
      4'hB:
      begin
        p.sig_chan = cps_pkg::SIG_CH4;
        p.op_mask  = cps_pkg::OP_2_6;
      end
      4'hC:
      begin
        p.sig_chan = cps_pkg::SIG_CH2;
        p.op_mask  = cps_pkg::OP_4_6;
      end
      4'hD:
      begin
        p.sig_chan = cps_pkg::SIG_CH5;
        p.op_mask  = cps_pkg::OP_1_3_7;
      end
      // Zero, and reserved E/F, take the custom group search
      default:
      begin
        p.auto_search = 1'b1;
      end
    endcase
    return p;
  endfunction

  // Capture path next values
  always_comb
  begin
    nxt_sync1 = sel_switch;
    nxt_sync2 = sync1_ff;
    nxt_rst_d = rst;
    nxt_sel   = sel_ff;
    nxt_plan  = plan_ff;
    // Load only on the first cycle after release; later moves ignored
    if (rst_d_ff && !rst)
    begin
      nxt_sel  = sync2_ff;
      nxt_plan = decode(sync2_ff);
    end
  end

  // Capture path registers; sync stages run through reset
  always_ff @(posedge clock)
  begin
    sync1_ff <= nxt_sync1;
    sync2_ff <= nxt_sync2;
    rst_d_ff <= nxt_rst_d;
    if (rst)
    begin
      sel_ff  <= cps_pkg::SEL_RST;
      plan_ff <= decode(cps_pkg::SEL_RST);
    end
    else
    begin
      sel_ff  <= nxt_sel;
      plan_ff <= nxt_plan;
    end
  end

  // Call setup sequencing: signal dwell, then operate
  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_dwell = dwell_ff;
    case (phase_ff)
      cps_pkg::CPS_IDLE:
      begin
        if (call_start)
        begin
          nxt_phase = cps_pkg::CPS_SIGNAL;
          nxt_dwell = 32'h0000_0000;
        end
      end
      cps_pkg::CPS_SIGNAL:
      begin
        // Half second on the signalling channel
        if (call_end)
          nxt_phase = cps_pkg::CPS_IDLE;
        else if (dwell_ff == 32'(DWELL_CYC - 1))
          nxt_phase = cps_pkg::CPS_OPERATE;
        else
          nxt_dwell = dwell_ff + 32'h0000_0001;
      end
      cps_pkg::CPS_OPERATE:
      begin
        if (call_end)
          nxt_phase = cps_pkg::CPS_IDLE;
      end
      default:
        nxt_phase = cps_pkg::CPS_IDLE;
    endcase
  end

  // Call setup registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase_ff <= cps_pkg::CPS_IDLE;
      dwell_ff <= 32'h0000_0000;
    end
    else
    begin
      phase_ff <= nxt_phase;
      dwell_ff <= nxt_dwell;
    end
  end

  // Heartbeat: toggle every half period for one flash per second
  always_comb
  begin
    nxt_beat = beat_ff + 32'h0000_0001;
    nxt_led  = led_ff;
    if (beat_ff == 32'(HEART_CYC - 1))
    begin
      nxt_beat = 32'h0000_0000;
      nxt_led  = !led_ff;
    end
  end

  // Heartbeat registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      beat_ff <= 32'h0000_0000;
      led_ff  <= 1'b0;
    end
    else
    begin
      beat_ff <= nxt_beat;
      led_ff  <= nxt_led;
    end
  end

  // Outputs; peers must share selector setting to link
  assign plan       = plan_ff;
  assign sel_value  = sel_ff;
  assign on_signal  = (phase_ff == cps_pkg::CPS_SIGNAL);
  assign on_operate = (phase_ff == cps_pkg::CPS_OPERATE);
  assign heartbeat  = led_ff;

endmodule

// File: test/cps_peer.sv
// Peer unit model: dials and hangs up calls towards the unit
`timescale 1ns/1ps
module cps_peer (
  // Clock and bench requests
  input  wire logic clock,
  input  wire logic dial,
  input  wire logic hang,
  // Call control into the unit
  output logic      call_start,
  output logic      call_end
);
  // One cycle late, as a far end behind a link would be
  always_ff @(posedge clock)
  begin
    call_start <= dial;
    call_end   <= hang;
  end
endmodule

// File: test/cps_top_chk.sv
// Checker for the channel plan selector ports
`timescale 1ns/1ps
module cps_top_chk #(
  parameter int unsigned DWELL_CYC = 10,
  parameter int unsigned HEART_CYC = 8
) (
  // Inputs of the unit
  input wire logic               clock,
  input wire logic               rst,
  input wire logic [3:0]         sel_switch,
  input wire logic               call_start,
  input wire logic               call_end,
  // Outputs of the unit
  input wire cps_pkg::cps_plan_s plan,
  input wire logic [3:0]         sel_value,
  input wire logic               on_signal,
  input wire logic               on_operate,
  input wire logic               heartbeat
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic        idle;    // Neither call phase
  logic        hb_ff;   // Last blink level
  logic [31:0] cnt_ff;  // Cycles since blink change
  logic [31:0] nxt_cnt;
  assign idle = !on_signal && !on_operate;
  // Count restarts on reset and on each blink edge
  always_comb nxt_cnt = (rst || heartbeat != hb_ff) ? 32'h0 : cnt_ff + 32'h1;
  always_ff @(posedge clock)
  begin
    cnt_ff <= nxt_cnt;
    hb_ff  <= heartbeat;
  end
  sequence s_taken;
    idle && call_start && !call_end;
  endsequence
  chk_sel_hold: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable(sel_value) && $stable(plan))
    else $error("selector moved while running");
  // Sampled release edge; the switch value needs two sync stages first
  chk_sel_load: assert property (
    $fell(rst) |=> sel_value == $past(sel_switch, 3))
    else $error("selector not captured at release");
  chk_pos_low: assert property (
    sel_value inside {[4'h1:4'h6]}
    |-> plan == {1'b0, 3'h7, 7'h01 << (sel_value - 4'h1)})
    else $error("low position plan wrong");
  chk_pos_auto: assert property (
    sel_value inside {4'h0, 4'hE, 4'hF} |-> plan == 11'h400)
    else $error("search plan wrong");
  chk_call_go: assert property (
    s_taken |=> on_signal && !on_operate)
    else $error("call start not taken");
  chk_call_stop: assert property (
    !idle && call_end |=> idle)
    else $error("call end not taken");
  chk_dwell_len: assert property (
    $rose(on_operate)
    |-> $past(on_signal, DWELL_CYC) && !$past(on_signal, DWELL_CYC + 1))
    else $error("dwell length wrong");
  chk_blink_rate: assert property (
    heartbeat != hb_ff && !heartbeat |-> cnt_ff == HEART_CYC - 1)
    else $error("blink period wrong");
  chk_blink_max: assert property (
    cnt_ff <= HEART_CYC + 1)
    else $error("blink stopped");
endmodule
bind cps_top cps_top_chk #(.DWELL_CYC(DWELL_CYC), .HEART_CYC(HEART_CYC))
  i_cps_top_chk (.clock(clock), .rst(rst), .sel_switch(sel_switch),
  .call_start(call_start), .call_end(call_end), .plan(plan),
  .sel_value(sel_value), .on_signal(on_signal), .on_operate(on_operate),
  .heartbeat(heartbeat));

// File: test/channel_plan_select_tb.sv
// Self-checking bench for the channel plan selector
`timescale 1ns/1ps
module channel_plan_select_tb;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               dial = 1'b0;
  logic               hang = 1'b0;
  logic [3:0]         sel_switch = 4'h0;
  logic [3:0]         sel_value;
  logic               call_start, call_end, on_signal, on_operate, heartbeat;
  cps_pkg::cps_plan_s plan;
  int                 fails = 0;
  int                 check_count = 0;
  always #4 clock = ~clock;
  // Short counts keep the run brief
  cps_top #(.DWELL_CYC(10), .HEART_CYC(8)) i_cps_top (.clock(clock),
    .rst(rst), .sel_switch(sel_switch), .call_start(call_start),
    .call_end(call_end), .plan(plan), .sel_value(sel_value),
    .on_signal(on_signal), .on_operate(on_operate), .heartbeat(heartbeat));
  cps_peer i_cps_peer (.clock(clock), .dial(dial), .hang(hang),
    .call_start(call_start), .call_end(call_end));
  task automatic check(logic [10:0] seen, logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // Plan word {search, signal, operate mask} per position
  function automatic logic [10:0] want(logic [3:0] v);
    case (v)
      4'h7: want = 11'h109;
      4'h8: want = 11'h150;
      4'h9: want = 11'h124;
      4'hA: want = 11'h191;
      4'hB: want = 11'h222;
      4'hC: want = 11'h128;
      4'hD: want = 11'h2C5;
      default: want = 11'h400;
    endcase
    if (v inside {[4'h1:4'h6]}) want = 11'h380 | (11'h001 << (v - 4'h1));
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic boot(logic [3:0] v);
    @(posedge clock);
    sel_switch <= v;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    tick(3);
  endtask
  task automatic tap(logic d, logic h);
    @(posedge clock);
    dial <= d;
    hang <= h;
    @(posedge clock);
    dial <= 1'b0;
    hang <= 1'b0;
  endtask
  task automatic t_plans();
    for (int v = 0; v < 16; v++)
    begin
      boot(4'(v));
      check(plan, want(4'(v)));
      check({7'h00, sel_value}, 11'(v));
    end
    $display("plans done");
  endtask
  task automatic t_hold();
    boot(4'h9);
    @(posedge clock);
    sel_switch <= 4'h3;
    tick(6);
    check(plan, 11'h124);
    check({7'h00, sel_value}, 11'h009);
    $display("hold done");
  endtask
  task automatic t_call();
    int n;
    boot(4'h8);
    tap(1'b1, 1'b0);
    n = 0;
    while (on_signal !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (on_signal === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    check(11'(n), 11'h00A);
    tap(1'b1, 1'b0);
    tick(3);
    check({on_signal, on_operate}, 11'h001);
    tap(1'b0, 1'b1);
    tick(3);
    check({on_signal, on_operate}, 11'h000);
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b1);
    tick(3);
    check({on_signal, on_operate}, 11'h000);
    $display("call done");
  endtask
  task automatic t_heart();
    int   n;
    logic b;
    boot(4'h0);
    for (int k = 0; k < 2; k++)
    begin
      b = heartbeat;
      n = 0;
      while (heartbeat === b && n < 40)
      begin
        tick(1);
        n++;
      end
    end
    check(11'(n), 11'h008);
    $display("heartbeat done");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    t_plans();
    t_hold();
    t_call();
    t_heart();
    print_verdict();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule
